//--- hdl/rdec_core.sv
// Read error capture, lock, lost-error and page-table retry logic.
// Behaviour
// - Fill error while locked keeps old report, sets only the lost flag.
// - Lost fill error causing machine check is a read and posts soft irq.
// - Unacknowledged reads leave their physical address in the fill address.
// - Processor parity error sets its flag, captures command, and low data unless an output error is captured in the same cycle.
// - Ownership read refusal enters transition mode; other reads never do.
// - Output error while locked keeps old report, sets only lost flag.
// - Failed page-table read sets its flag and aborts the miss.
// - Execution unit references retry a failed page-table read once by probe.
// - Failed probe takes machine check; passing probe restarts stream.
// - Page-table error on a write sets the write flag, drops the write.
// - String instructions report next address as pc, current as saved pc.
// - Saved pc is undefined outside the string instruction case.
// - Return-from-exception target fetch fault reports that target as pc.
`timescale 1ns/1ps
module rdec_core
    import rdec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fill_err,
    input wire logic [1:0] fill_kind,
    input wire logic fill_is_write,
    input wire logic fill_rde,
    input wire logic fill_noack,
    input wire logic fill_tmo,
    input wire logic [31:0] fill_addr,
    input wire logic out_err,
    input wire logic [31:0] out_cmd,
    input wire logic [31:0] out_addr,
    input wire logic [31:0] out_dhi,
    input wire logic [31:0] out_dlo,
    input wire logic out_noack,
    input wire logic par_err,
    input wire logic [31:0] in_cmd,
    input wire logic [31:0] in_dlo,
    input wire logic pte_err,
    input wire logic pte_ebox,
    input wire logic pte_write,
    input wire logic pte_string,
    input wire logic pte_rei,
    input wire logic [31:0] cur_pc,
    input wire logic [31:0] next_pc,
    input wire logic probe_done,
    input wire logic probe_fail,
    output logic miss_abort,
    output logic force_mm_fault,
    output logic restart_stream,
    output logic machine_check,
    output logic irq
);
    logic [5:0] fill_sts_q;
    logic [31:0] fill_adr_q;
    logic [3:0] bus_sts_q;
    logic [31:0] ocmd_q, oadr_q, dhi_q, dlo_q, icmd_q;
    logic [1:0] xlt_sts_q;
    logic etm_q;
    logic [31:0] fpc_q, spc_q;
    logic [RDEC_IRQ_W-1:0] irq_sts_q, irq_msk_q;
    rdec_pt_state_t pt_q;
    logic wr_en, rd_en;
    logic [RDEC_IRQ_W-1:0] irq_set;
    logic mchk_set;

    function automatic logic w1c(input logic cur, input logic set,
                                 input logic clr);
        // A new event beats a clear in the same cycle.
        w1c = set | (cur & ~clr);
    endfunction

    function automatic logic hit(input logic [7:0] off);
        hit = wr_en && (paddr == off);
    endfunction

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign mchk_set = pt_q == RDEC_PT_PROBE && probe_done && probe_fail;
    always_comb begin
        irq_set = '0;
        irq_set[RDEC_IRQ_SOFT] = fill_err | out_err | par_err;
        irq_set[RDEC_IRQ_MCHK] = mchk_set;
    end

    // Fill error capture with lock and lost indication.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_sts_q <= '0;
            fill_adr_q <= RDEC_ZERO;
        end else begin
            // Capture only while unlocked, so one report stays whole.
            if (fill_err && !fill_sts_q[RDEC_FS_LOCK]) begin
                fill_sts_q[RDEC_FS_LOCK] <= 1'b1;
                fill_sts_q[RDEC_FS_RDE] <= fill_rde;
                fill_sts_q[RDEC_FS_NOACK] <= fill_noack;
                fill_sts_q[RDEC_FS_TMO] <= fill_tmo;
                fill_sts_q[RDEC_FS_WRITE] <= fill_is_write;
                fill_sts_q[RDEC_FS_LOST] <= w1c(fill_sts_q[RDEC_FS_LOST],
                    1'b0, hit(RDEC_FILL_STS_OFF) & pwdata[RDEC_FS_LOST]);
                fill_adr_q <= fill_addr;
            end else begin
                // Locked: later errors only mark the report as lost.
                for (int i = 0; i < 6; i++) begin
                    fill_sts_q[i] <= w1c(fill_sts_q[i],
                        i == RDEC_FS_LOST && fill_err,
                        hit(RDEC_FILL_STS_OFF) & pwdata[i]);
                end
            end
        end
    end

    // Bus output error capture and processor parity capture.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_sts_q <= '0;
            ocmd_q <= RDEC_ZERO;
            oadr_q <= RDEC_ZERO;
            dhi_q <= RDEC_ZERO;
            dlo_q <= RDEC_ZERO;
        end else begin
            if (out_err && !bus_sts_q[RDEC_BS_LOCK]) begin
                bus_sts_q[RDEC_BS_LOCK] <= 1'b1;
                bus_sts_q[RDEC_BS_NOACK] <= out_noack;
                ocmd_q <= out_cmd;
                oadr_q <= out_addr;
                dhi_q <= out_dhi;
                dlo_q <= out_dlo;
            end else begin
                for (int i = 0; i < 3; i++) begin
                    bus_sts_q[i] <= w1c(bus_sts_q[i],
                        i == RDEC_BS_LOST && out_err,
                        hit(RDEC_BUS_STS_OFF) & pwdata[i]);
                end
            end
            bus_sts_q[RDEC_BS_PROCESSOR_PARITY_ERROR_FLAG] <= w1c(bus_sts_q[RDEC_BS_PROCESSOR_PARITY_ERROR_FLAG], par_err,
                hit(RDEC_BUS_STS_OFF) & pwdata[RDEC_BS_PROCESSOR_PARITY_ERROR_FLAG]);
            // Low data capture yields to a same-cycle output error report.
            if (par_err) begin
                if (!(out_err && !bus_sts_q[RDEC_BS_LOCK])) begin
                    dlo_q <= in_dlo;
                end
            end
        end
    end

    // Incoming command capture has no lock: the latest parity error wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            icmd_q <= RDEC_ZERO;
        end else if (par_err) begin
            icmd_q <= in_cmd;
        end
    end

    // Transition mode: forced on ownership read refusal, held until cleared.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            etm_q <= 1'b0;
        end else begin
            etm_q <= w1c(etm_q, fill_err && fill_noack &&
                fill_kind == RDEC_REF_OWN,
                hit(RDEC_CACHE_CONTROL_REG_OFF) & pwdata[RDEC_CC_ETM]);
        end
    end

    // Page-table read error handling and single probe retry.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pt_q <= RDEC_PT_IDLE;
            xlt_sts_q <= '0;
            miss_abort <= 1'b0;
            force_mm_fault <= 1'b0;
            restart_stream <= 1'b0;
            machine_check <= 1'b0;
            fpc_q <= RDEC_ZERO;
            spc_q <= RDEC_ZERO;
        end else begin
            // Every miss error aborts the walk, whichever unit asked.
            miss_abort <= pte_err;
            force_mm_fault <= 1'b0;
            restart_stream <= 1'b0;
            machine_check <= 1'b0;
            xlt_sts_q[RDEC_XS_PTE] <= w1c(xlt_sts_q[RDEC_XS_PTE], pte_err,
                hit(RDEC_XLT_STS_OFF) & pwdata[RDEC_XS_PTE]);
            xlt_sts_q[RDEC_XS_PTE_WR] <= w1c(xlt_sts_q[RDEC_XS_PTE_WR],
                pte_err & pte_write,
                hit(RDEC_XLT_STS_OFF) & pwdata[RDEC_XS_PTE_WR]);
            if (pte_err) begin
                if (pte_ebox && pte_string && !pte_rei) begin
                    fpc_q <= next_pc;
                    spc_q <= cur_pc;
                end else if (pte_rei) begin
                    fpc_q <= cur_pc;
                end else begin
                    // Saved pc keeps a stale value; nothing may rely on it.
                    fpc_q <= cur_pc;
                end
            end
            // Only execution-unit misses get the probe retry; others trap.
            case (pt_q)
                RDEC_PT_IDLE: begin
                    if (pte_err && pte_ebox) begin
                        force_mm_fault <= 1'b1;
                        pt_q <= RDEC_PT_PROBE;
                    end else if (pte_err) begin
                        machine_check <= 1'b1;
                    end else if (fill_err && fill_sts_q[RDEC_FS_LOCK] &&
                                 fill_noack && !fill_is_write) begin
                        machine_check <= 1'b1;
                    end
                end
                RDEC_PT_PROBE: begin
                    if (probe_done) begin
                        machine_check <= probe_fail;
                        restart_stream <= !probe_fail;
                        pt_q <= RDEC_PT_DONE;
                    end
                end
                RDEC_PT_DONE: begin
                    // One idle cycle keeps a new miss off the result pulse.
                    pt_q <= RDEC_PT_IDLE;
                end
                default: begin
                    pt_q <= RDEC_PT_IDLE;
                end
            endcase
        end
    end

    // Interrupt status, mask and output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sts_q <= '0;
            irq_msk_q <= '0;
            irq <= 1'b0;
        end else begin
            for (int i = 0; i < RDEC_IRQ_W; i++) begin
                irq_sts_q[i] <= w1c(irq_sts_q[i], irq_set[i],
                    hit(RDEC_IRQ_STS_OFF) & pwdata[i]);
            end
            if (hit(RDEC_IRQ_MSK_OFF)) begin
                irq_msk_q <= pwdata[RDEC_IRQ_W-1:0];
            end
            // New events count at once, so irq does not wait a cycle.
            irq <= |((irq_sts_q | irq_set) & irq_msk_q);
        end
    end

    // Read decode; unknown and misaligned offsets read as zero.
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        case (a)
            RDEC_FILL_STS_OFF: rd_word = {26'h0, fill_sts_q};
            RDEC_FILL_ADR_OFF: rd_word = fill_adr_q;
            RDEC_BUS_STS_OFF: rd_word = {28'h0, bus_sts_q};
            RDEC_OCMD_OFF: rd_word = ocmd_q;
            RDEC_OADR_OFF: rd_word = oadr_q;
            RDEC_DHI_OFF: rd_word = dhi_q;
            RDEC_DLO_OFF: rd_word = dlo_q;
            RDEC_ICMD_OFF: rd_word = icmd_q;
            RDEC_XLT_STS_OFF: rd_word = {30'h0, xlt_sts_q};
            RDEC_CACHE_CONTROL_REG_OFF: rd_word = {31'h0, etm_q};
            RDEC_PC_OFF: rd_word = fpc_q;
            RDEC_SPC_OFF: rd_word = spc_q;
            RDEC_IRQ_STS_OFF: rd_word = {30'h0, irq_sts_q};
            RDEC_IRQ_MSK_OFF: rd_word = {30'h0, irq_msk_q};
            default: rd_word = RDEC_ZERO;
        endcase
    endfunction

    // APB slave: one wait-free access phase after every setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr[1:0] != 2'b00 ||
                paddr > RDEC_IRQ_MSK_OFF);
        end
    end

    // Read data is latched in setup so it stands through the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RDEC_ZERO;
        end else if (rd_en) begin
            prdata <= rd_word(paddr);
        end
    end
endmodule

//--- pkg/rdec_pkg.sv
// Package with register map, field positions and state codes for read error capture.
package rdec_pkg;
    localparam logic [7:0] RDEC_FILL_STS_OFF = 8'h00;
    localparam logic [7:0] RDEC_FILL_ADR_OFF = 8'h04;
    localparam logic [7:0] RDEC_BUS_STS_OFF = 8'h08;
    localparam logic [7:0] RDEC_OCMD_OFF = 8'h0C;
    localparam logic [7:0] RDEC_OADR_OFF = 8'h10;
    localparam logic [7:0] RDEC_DHI_OFF = 8'h14;
    localparam logic [7:0] RDEC_DLO_OFF = 8'h18;
    localparam logic [7:0] RDEC_ICMD_OFF = 8'h1C;
    localparam logic [7:0] RDEC_XLT_STS_OFF = 8'h20;
    localparam logic [7:0] RDEC_CACHE_CONTROL_REG_OFF = 8'h24;
    localparam logic [7:0] RDEC_PC_OFF = 8'h28;
    localparam logic [7:0] RDEC_SPC_OFF = 8'h2C;
    localparam logic [7:0] RDEC_IRQ_STS_OFF = 8'h30;
    localparam logic [7:0] RDEC_IRQ_MSK_OFF = 8'h34;
    // Fill error status fields.
    localparam int RDEC_FS_LOCK = 0;
    localparam int RDEC_FS_LOST = 1;
    localparam int RDEC_FS_RDE = 2;
    localparam int RDEC_FS_NOACK = 3;
    localparam int RDEC_FS_TMO = 4;
    localparam int RDEC_FS_WRITE = 5;
    // Bus error status fields.
    localparam int RDEC_BS_LOCK = 0;
    localparam int RDEC_BS_LOST = 1;
    localparam int RDEC_BS_NOACK = 2;
    localparam int RDEC_BS_PROCESSOR_PARITY_ERROR_FLAG = 3;
    // Translation error status fields.
    localparam int RDEC_XS_PTE = 0;
    localparam int RDEC_XS_PTE_WR = 1;
    // Cache control field.
    localparam int RDEC_CC_ETM = 0;
    // Interrupt status fields.
    localparam int RDEC_IRQ_SOFT = 0;
    localparam int RDEC_IRQ_MCHK = 1;
    localparam int RDEC_IRQ_W = 2;
    localparam logic [31:0] RDEC_ZERO = 32'h0000_0000;
    // Reference kind codes.
    localparam logic [1:0] RDEC_REF_IST = 2'h0;
    localparam logic [1:0] RDEC_REF_DST = 2'h1;
    localparam logic [1:0] RDEC_REF_OWN = 2'h2;
    typedef enum logic [1:0] {
        RDEC_PT_IDLE = 2'b00,
        RDEC_PT_PROBE = 2'b01,
        RDEC_PT_DONE = 2'b10
    } rdec_pt_state_t;
endpackage

//--- verification/rdec_bridge.sv
// Behavioural bus bridge that answers processor reads with error cycles.
`timescale 1ns/1ps
module rdec_bridge (
    input wire logic pclk,
    input wire logic rd_req,
    input wire logic [1:0] rd_kind,
    input wire logic [31:0] rd_addr,
    input wire logic refuse,
    output logic fill_err,
    output logic fill_noack,
    output logic fill_rde,
    output logic [1:0] fill_kind,
    output logic [31:0] fill_addr
);
    // Only failing reads are modelled; a good fill never reaches this block.
    initial begin
        {fill_err, fill_noack, fill_rde, fill_kind, fill_addr} = '0;
    end
    always @(posedge pclk) begin
        fill_err <= rd_req;
        fill_noack <= rd_req & refuse;
        fill_rde <= rd_req & ~refuse;
        fill_kind <= rd_kind;
        // Idle address lines wander so a stale capture cannot pass unseen.
        fill_addr <= rd_req ? rd_addr : ~fill_addr;
    end
endmodule

//--- verification/rdec_chk.sv
// Checker with port-level assertions for the read error capture core.
`timescale 1ns/1ps
module rdec_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pte_err,
    input wire logic pte_ebox,
    input wire logic probe_done,
    input wire logic probe_fail,
    input wire logic miss_abort,
    input wire logic force_mm_fault,
    input wire logic restart_stream,
    input wire logic machine_check
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_ebox_miss; pte_err && pte_ebox; endsequence
    sequence s_probe_bad; probe_done && probe_fail; endsequence
    a_pte_abort: assert property (pte_err |=> miss_abort)
        else $error("miss not aborted");
    a_ebox_probe: assert property (s_ebox_miss |-> ##[1:2] force_mm_fault)
        else $error("probe not forced");
    a_probe_single: assert property (force_mm_fault |=> !force_mm_fault [*3])
        else $error("probe forced twice");
    a_probe_fail: assert property (s_probe_bad |=> machine_check && !restart_stream)
        else $error("failed probe without check");
    a_probe_pass: assert property (probe_done && !probe_fail |=> restart_stream && !machine_check)
        else $error("passing probe without restart");
    a_other_check: assert property (pte_err && !pte_ebox |-> ##[1:2] machine_check)
        else $error("miss error without check");
    a_other_noprobe: assert property (pte_err && !pte_ebox |=> !force_mm_fault [*2])
        else $error("probe forced for other unit");
    a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bus answer timing wrong");
endmodule
bind rdec_core rdec_chk rdec_chk_inst (.*);

//--- verification/tb.sv
// Self-checking bench for the read error capture core.
`timescale 1ns/1ps
module tb
    import rdec_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, fill_addr, out_cmd, out_addr, out_dhi, rv;
    logic [31:0] out_dlo, in_cmd, in_dlo, cur_pc, next_pc, rd_addr;
    logic [1:0] fill_kind, rd_kind;
    logic fill_err, fill_is_write, fill_rde, fill_noack, fill_tmo, out_err;
    logic out_noack, par_err, pte_err, pte_ebox, pte_write, pte_string;
    logic pte_rei, probe_done, probe_fail, miss_abort, force_mm_fault;
    logic restart_stream, machine_check, irq, rd_req, refuse;
    int n_errors, n_checks, n_mchk, n_rst, n_frc;
    rdec_core rdec_core_inst (.*);
    rdec_bridge rdec_bridge_inst (.*);
    task test_done;
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Trailing idle cycle keeps two transfers from driving psel in one step.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        do tick(1); while (pready !== 1'b1);
        slv_err = pslverr;
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, RDEC_ZERO);
        chk(rv, exp);
    endtask
    task brd(input logic [1:0] k, input logic [31:0] a, input logic r);
        rd_req <= 1'b1;
        rd_kind <= k;
        rd_addr <= a;
        refuse <= r;
        tick(1);
        rd_req <= 1'b0;
        tick(3);
    endtask
    task oerr(input logic [31:0] v);
        {out_cmd, out_addr, out_dhi, out_dlo} <= {v, ~v, v ^ 32'h0000_FF00, v};
        out_noack <= 1'b1;
        out_err <= 1'b1;
        tick(1);
        out_err <= 1'b0;
        tick(2);
    endtask
    task pte_run(input logic e, s, w, r, input logic [31:0] c, input logic f);
        int i;
        {pte_ebox, pte_string, pte_write, pte_rei} <= {e, s, w, r};
        cur_pc <= c;
        next_pc <= c + 32'h0000_0004;
        pte_err <= 1'b1;
        tick(1);
        pte_err <= 1'b0;
        for (i = 0; i < 8 && e && force_mm_fault !== 1'b1; i++) tick(1);
        probe_fail <= f;
        probe_done <= e;
        tick(1);
        probe_done <= 1'b0;
        tick(3);
    endtask
    task t_fill;
        brd(RDEC_REF_OWN, 32'h0000_1240, 1'b1);
        rd(RDEC_FILL_ADR_OFF, 32'h0000_1240);
        rd(RDEC_FILL_STS_OFF, 32'h0000_0009);
        rd(RDEC_CACHE_CONTROL_REG_OFF, 32'h0000_0001);
        brd(RDEC_REF_DST, 32'h0000_5680, 1'b1);
        rd(RDEC_FILL_ADR_OFF, 32'h0000_1240);
        rd(RDEC_FILL_STS_OFF, 32'h0000_000B);
        chk(n_mchk, 32'h0000_0001);
        rd(RDEC_IRQ_STS_OFF, 32'h0000_0001);
        chk(irq, 1'b0);
        apb(1'b1, RDEC_IRQ_MSK_OFF, 32'h0000_0001);
        tick(1);
        chk(irq, 1'b1);
        apb(1'b1, RDEC_IRQ_STS_OFF, 32'h0000_0001);
        tick(1);
        chk(irq, 1'b0);
        apb(1'b1, RDEC_FILL_STS_OFF, 32'h0000_000B);
        rd(RDEC_FILL_STS_OFF, RDEC_ZERO);
        brd(RDEC_REF_IST, 32'h0000_2000, 1'b0);
        rd(RDEC_FILL_ADR_OFF, 32'h0000_2000);
        rd(RDEC_FILL_STS_OFF, 32'h0000_0005);
        apb(1'b1, RDEC_FILL_STS_OFF, 32'h0000_0005);
        {fill_is_write, fill_tmo} <= 2'b11;
        brd(RDEC_REF_DST, 32'h0000_3000, 1'b0);
        rd(RDEC_FILL_STS_OFF, 32'h0000_0035);
        brd(RDEC_REF_DST, 32'h0000_3400, 1'b1);
        rd(RDEC_FILL_STS_OFF, 32'h0000_0037);
        rd(RDEC_FILL_ADR_OFF, 32'h0000_3000);
        chk(n_mchk, 32'h0000_0001);
        {fill_is_write, fill_tmo} <= 2'b00;
    endtask
    task t_bus;
        {in_cmd, in_dlo} <= {32'h0000_00A5, 32'h0000_5A5A};
        par_err <= 1'b1;
        tick(1);
        par_err <= 1'b0;
        tick(2);
        rd(RDEC_BUS_STS_OFF, 32'h0000_0008);
        rd(RDEC_ICMD_OFF, 32'h0000_00A5);
        rd(RDEC_DLO_OFF, 32'h0000_5A5A);
        oerr(32'h0000_0011);
        rd(RDEC_BUS_STS_OFF, 32'h0000_000D);
        oerr(32'h0000_0022);
        rd(RDEC_BUS_STS_OFF, 32'h0000_000F);
        rd(RDEC_OADR_OFF, 32'hFFFF_FFEE);
        rd(RDEC_DHI_OFF, 32'h0000_FF11);
    endtask
    task t_pte;
        pte_run(1'b1, 1'b1, 1'b1, 1'b0, 32'h0000_0100, 1'b1);
        rd(RDEC_PC_OFF, 32'h0000_0104);
        rd(RDEC_SPC_OFF, 32'h0000_0100);
        rd(RDEC_XLT_STS_OFF, 32'h0000_0003);
        chk(n_mchk, 32'h0000_0002);
        rd(RDEC_IRQ_STS_OFF, 32'h0000_0003);
        apb(1'b1, RDEC_XLT_STS_OFF, 32'h0000_0003);
        pte_run(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0200, 1'b0);
        rd(RDEC_PC_OFF, 32'h0000_0200);
        rd(RDEC_XLT_STS_OFF, 32'h0000_0001);
        chk(n_rst, 32'h0000_0001);
        pte_run(1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_0300, 1'b0);
        rd(RDEC_PC_OFF, 32'h0000_0300);
        chk(n_frc, 32'h0000_0002);
        chk(n_mchk, 32'h0000_0003);
        rd(8'h38, RDEC_ZERO);
        chk(slv_err, 1'b1);
    endtask
    always @(posedge pclk) begin
        if (machine_check === 1'b1) n_mchk <= n_mchk + 1;
        if (restart_stream === 1'b1) n_rst <= n_rst + 1;
        if (force_mm_fault === 1'b1) n_frc <= n_frc + 1;
    end
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        test_done();
    end
    initial begin
        {presetn, psel, penable, pwrite, fill_is_write, fill_tmo} = '0;
        {out_err, out_noack, par_err, pte_err, pte_ebox, pte_write} = '0;
        {pte_string, pte_rei, probe_done, probe_fail, rd_req, refuse} = '0;
        {paddr, pwdata, out_cmd, out_addr, out_dhi, out_dlo} = '0;
        {in_cmd, in_dlo, cur_pc, next_pc, rd_addr, rd_kind} = '0;
        {n_errors, n_checks, n_mchk, n_rst, n_frc} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        chk(irq, 1'b0);
        t_fill();
        t_bus();
        t_pte();
        test_done();
    end
endmodule
